//--- logic/smld_pkg.sv
// Package of constants and types for the status and multiplicand load unit.
package smld_pkg;

    typedef enum logic [2:0] {
        SMLD_OP_RELOAD_ST0,
        SMLD_OP_RELOAD_ST1,
        SMLD_OP_MPCD_LOAD,
        SMLD_OP_MPCD_ACC,
        SMLD_OP_MPCD_MOVE,
        SMLD_OP_MPCD_PROD
    } smld_op_t;

    typedef struct packed {
        smld_op_t    op;
        logic        indirect;
        logic [6:0]  offset;
        logic [15:0] aux_addr;
        logic        next_valid;
        logic [2:0]  next_ptr;
    } smld_req_t;

    // Variants of the processor.
    localparam logic [1:0] SMLD_VAR_FULL    = 2'h0;
    localparam logic [1:0] SMLD_VAR_REDUCED = 2'h1;
    localparam logic [1:0] SMLD_VAR_MEMSEL  = 2'h2;

    // Status word zero fields.
    localparam int ST0_PTR_LSB   = 13;
    localparam int ST0_OV_BIT    = 12;
    localparam int ST0_SAT_BIT   = 11;
    localparam int ST0_ONE_BIT   = 10;
    localparam int ST0_INTERRUPT_MASK_MODE_BIT  = 9;
    localparam int ST0_PAGE_LSB  = 0;
    localparam logic [15:0] ST0_RESET = 16'h0600;

    // Status word one fields.
    localparam int ST1_BUF_LSB   = 13;
    localparam int ST1_CNF_BIT   = 12;
    localparam int ST1_ONE_BIT   = 8;
    localparam int ST1_CFGH_BIT  = 7;
    localparam int ST1_XF_BIT    = 4;
    localparam int ST1_PM_LSB    = 0;
    localparam logic [15:0] ST1_RESET    = 16'h0180;
    localparam logic [15:0] ST1_RED_ONES = 16'h0260;

    // Data memory map.
    localparam logic [15:0] MAP_MMR_TOP  = 16'h0005;
    localparam logic [15:0] MAP_B2_LO    = 16'h0060;
    localparam logic [15:0] MAP_B2_HI    = 16'h007F;
    localparam logic [15:0] MAP_B0_LO    = 16'h0200;
    localparam logic [15:0] MAP_B0_HI    = 16'h02FF;
    localparam logic [15:0] MAP_B1_HI    = 16'h03FF;

endpackage

//--- logic/smld_unit.sv
// Execution unit for status word reloads and multiplicand register loads.
// Contract
// - Status zero reload replaces every field except interrupt mask mode.
// - Status zero reload never copies old pointer into pointer buffer.
// - Status zero reload ignores any next-pointer operand in indirect mode.
// - Memory-select variant keeps config selects in status one bits 12, 7.
// - Move load loads multiplicand and adds shifted product to accumulator.
// - Move load also writes the word to the next higher address.
// - Move works in blocks one, two, and zero when zero is data.
// - Move crosses block zero/one boundary; never external or mapped regs.
// - Move load on external memory acts as accumulate load.
// - Accumulate load loads multiplicand and adds shifted product.
// - Internal operand takes one cycle; external two plus wait states.
// - Repeated operations cost the single-operation time per repetition.
// - Pointer change by operand copies old pointer into pointer buffer.
// - Nine-bit page pointer and seven-bit offset form direct address.
module smld_unit
    import smld_pkg::*;
#(
    parameter logic [1:0] VARIANT = SMLD_VAR_FULL
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Operation request.
    input  wire logic        op_valid,
    output logic             op_ready,
    input  wire smld_req_t   op_req,
    output logic             op_done,
    // Data memory read.
    output logic [15:0]      mem_raddr,
    output logic             mem_rd,
    input  wire logic [15:0] mem_rdata,
    input  wire logic        ext_wait,
    // Data memory write for the data move.
    output logic             mem_wr,
    output logic [15:0]      mem_waddr,
    output logic [15:0]      mem_wdata,
    // Multiplier and accumulator.
    input  wire logic [31:0] product,
    output logic [15:0]      multiplicand,
    output logic [31:0]      accumulator,
    // Status words and pins.
    output logic [15:0]      status_word_zero,
    output logic [15:0]      status_word_one,
    output logic             external_flag_pin
);

    typedef enum logic [0:0] {
        SMLD_IDLE,
        SMLD_EXT
    } smld_state_t;

    smld_state_t state_q;
    smld_state_t state_d;
    smld_req_t   req_q;
    logic [15:0] st0_q;
    logic [15:0] st0_d;
    logic [15:0] st1_q;
    logic [15:0] st1_d;
    logic [15:0] mpcd_q;
    logic [15:0] mpcd_d;
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic        done_q;
    logic        wr_q;
    logic [15:0] waddr_q;
    logic [15:0] wdata_q;

    // Address formation for the request being started or finished.
    wire logic        idle      = (state_q == SMLD_IDLE);
    wire smld_req_t   cur_req   = idle ? op_req : req_q;
    wire logic [8:0]  page      = st0_q[ST0_PAGE_LSB +: 9];
    wire logic [15:0] dir_addr  = {page, cur_req.offset};
    wire logic [15:0] cur_addr  = cur_req.indirect ? cur_req.aux_addr
                                                   : dir_addr;
    wire logic        cur_ext   = (cur_addr > MAP_B1_HI);

    // Execution happens at the one internal cycle or at the end of waits.
    wire logic start    = idle & op_valid;
    wire logic fire_int = start & ~cur_ext;
    wire logic fire_ext = ~idle & ~ext_wait;
    wire logic fire     = fire_int | fire_ext;

    // Region decode for the data move.
    wire logic b0_data  = ~st1_q[ST1_CNF_BIT];
    wire logic in_b2    = (cur_addr >= MAP_B2_LO) & (cur_addr <= MAP_B2_HI);
    wire logic in_b0    = (cur_addr >= MAP_B0_LO) & (cur_addr <= MAP_B0_HI);
    wire logic in_b1    = (cur_addr > MAP_B0_HI) & (cur_addr <= MAP_B1_HI);
    wire logic in_mmr   = (cur_addr <= MAP_MMR_TOP);
    wire logic move_ok  = ~cur_ext & ~in_mmr
                        & (in_b1 | in_b2 | (in_b0 & b0_data));
    wire logic is_move  = (cur_req.op == SMLD_OP_MPCD_MOVE);
    wire logic do_move  = fire & is_move & move_ok;

    // Product shift selected by the product shift mode.
    wire logic [1:0]  pm_sel  = st1_q[ST1_PM_LSB +: 2];
    logic      [31:0] prod_sh;
    always_comb begin
        case (pm_sel)
            2'h1:    prod_sh = {product[30:0], 1'b0};
            2'h2:    prod_sh = {product[27:0], 4'h0};
            2'h3:    prod_sh = {{6{product[31]}}, product[31:6]};
            default: prod_sh = product;
        endcase
    end

    // Accumulate with overflow detection and optional saturation.
    wire logic [31:0] sum     = acc_q + prod_sh;
    wire logic        sum_ovf = (acc_q[31] == prod_sh[31])
                              & (sum[31] != acc_q[31]);
    wire logic        sat_on  = st0_q[ST0_SAT_BIT];
    wire logic [31:0] sat_val = acc_q[31] ? 32'h8000_0000 : 32'h7FFF_FFFF;
    wire logic [31:0] acc_sum = (sum_ovf & sat_on) ? sat_val : sum;

    // Next pointer handling for operations other than status zero reload.
    wire logic ptr_load = cur_req.indirect & cur_req.next_valid;

    // Status one value as loaded, with variant-fixed bits applied.
    logic [15:0] st1_load;
    always_comb begin
        st1_load = mem_rdata;
        st1_load[ST1_ONE_BIT] = 1'b1;
        if (VARIANT != SMLD_VAR_MEMSEL) begin
            st1_load[ST1_CFGH_BIT] = 1'b1;
        end
        if (VARIANT == SMLD_VAR_REDUCED) begin
            st1_load = st1_load | ST1_RED_ONES;
        end
    end

    always_comb begin
        st0_d  = st0_q;
        st1_d  = st1_q;
        mpcd_d = mpcd_q;
        acc_d  = acc_q;
        if (fire) begin
            case (cur_req.op)
                SMLD_OP_RELOAD_ST0: begin
                    st0_d = mem_rdata;
                    st0_d[ST0_INTERRUPT_MASK_MODE_BIT] = st0_q[ST0_INTERRUPT_MASK_MODE_BIT];
                    st0_d[ST0_ONE_BIT]  = 1'b1;
                    // Buffer untouched and next pointer ignored here.
                    st1_d = st1_q;
                end
                SMLD_OP_RELOAD_ST1: begin
                    st1_d = st1_load;
                    st0_d[ST0_PTR_LSB +: 3] =
                        st1_load[ST1_BUF_LSB +: 3];
                end
                SMLD_OP_MPCD_LOAD: begin
                    mpcd_d = mem_rdata;
                end
                SMLD_OP_MPCD_ACC,
                SMLD_OP_MPCD_MOVE: begin
                    mpcd_d = mem_rdata;
                    acc_d  = acc_sum;
                    if (sum_ovf) begin
                        st0_d[ST0_OV_BIT] = 1'b1;
                    end
                end
                SMLD_OP_MPCD_PROD: begin
                    mpcd_d = mem_rdata;
                    acc_d  = prod_sh;
                end
                default: begin
                    mpcd_d = mpcd_q;
                end
            endcase
            if (cur_req.op != SMLD_OP_RELOAD_ST0 && ptr_load) begin
                st1_d[ST1_BUF_LSB +: 3] = st0_d[ST0_PTR_LSB +: 3];
                st0_d[ST0_PTR_LSB +: 3] = cur_req.next_ptr;
            end
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            SMLD_IDLE: begin
                if (start & cur_ext) begin
                    state_d = SMLD_EXT;
                end
            end
            SMLD_EXT: begin
                if (~ext_wait) begin
                    state_d = SMLD_IDLE;
                end
            end
            default: state_d = SMLD_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= SMLD_IDLE;
            req_q   <= '0;
            st0_q   <= ST0_RESET;
            st1_q   <= ST1_RESET;
            mpcd_q  <= 16'h0000;
            acc_q   <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            if (start) begin
                req_q <= op_req;
            end
            st0_q  <= st0_d;
            st1_q  <= st1_d;
            mpcd_q <= mpcd_d;
            acc_q  <= acc_d;
        end
    end

    // The move write follows the read by one cycle.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done_q  <= 1'b0;
            wr_q    <= 1'b0;
            waddr_q <= 16'h0000;
            wdata_q <= 16'h0000;
        end else begin
            done_q <= fire;
            wr_q   <= do_move;
            if (do_move) begin
                waddr_q <= cur_addr + 16'h0001;
                wdata_q <= mem_rdata;
            end
        end
    end

    assign op_ready          = idle;
    assign op_done           = done_q;
    assign mem_raddr         = cur_addr;
    assign mem_rd            = start | ~idle;
    assign mem_wr            = wr_q;
    assign mem_waddr         = waddr_q;
    assign mem_wdata         = wdata_q;
    assign multiplicand      = mpcd_q;
    assign accumulator       = acc_q;
    assign status_word_zero  = st0_q;
    assign status_word_one   = st1_q;
    assign external_flag_pin = st1_q[ST1_XF_BIT];

endmodule

//--- dv/smld_chk.sv
// Checker of the status and multiplicand load unit.
module smld_chk
    import smld_pkg::*;
(
    // Clock, reset and request.
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        op_valid,
    input wire logic        op_ready,
    input wire smld_req_t   op_req,
    input wire logic        op_done,
    // Memory and results.
    input wire logic [15:0] mem_raddr,
    input wire logic [15:0] mem_rdata,
    input wire logic        mem_wr,
    input wire logic [15:0] mem_waddr,
    input wire logic [15:0] mem_wdata,
    input wire logic [15:0] multiplicand,
    input wire logic [31:0] accumulator,
    input wire logic [15:0] status_word_zero,
    input wire logic [15:0] status_word_one
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // An operation taken with its operand in on-chip memory.
    wire logic     tk_int = op_valid && op_ready && mem_raddr <= MAP_B1_HI;
    wire smld_op_t op     = op_req.op;

    int_done_a: assert property (
        tk_int |=> op_done)
        else $error("internal operation late");
    ext_wait_a: assert property (
        op_valid && op_ready && !tk_int |=> !op_ready && !op_done)
        else $error("external operation too early");
    keep_mask_a: assert property (
        tk_int && op == SMLD_OP_RELOAD_ST0 |=> status_word_zero ==
        ($past(mem_rdata) & 16'hFDFF | $past(status_word_zero) & 16'h0200
        | 16'h0400) && status_word_one >> 13 == $past(status_word_one) >> 13)
        else $error("status zero reload wrong");
    st1_load_a: assert property (
        tk_int && op == SMLD_OP_RELOAD_ST1 && !op_req.next_valid |=>
        status_word_one == ($past(mem_rdata) | 16'h0180)
        && status_word_zero >> 13 == $past(mem_rdata) >> 13)
        else $error("status one reload wrong");
    plain_ld_a: assert property (
        tk_int && op == SMLD_OP_MPCD_LOAD && !op_req.next_valid |=>
        $stable(accumulator) && $stable(status_word_zero))
        else $error("plain load changed other state");
    mpcd_ld_a: assert property (
        tk_int && op inside {SMLD_OP_MPCD_LOAD, SMLD_OP_MPCD_ACC,
        SMLD_OP_MPCD_MOVE, SMLD_OP_MPCD_PROD} |=>
        multiplicand == $past(mem_rdata))
        else $error("multiplicand not loaded");
    move_wr_a: assert property (
        tk_int && op == SMLD_OP_MPCD_MOVE && (mem_raddr inside
        {[16'h0300:16'h03FE], [MAP_B2_LO:16'h007E]} || !status_word_one[12]
        && mem_raddr inside {[MAP_B0_LO:MAP_B0_HI]}) |=> mem_wr
        && mem_waddr == $past(mem_raddr) + 16'h0001
        && mem_wdata == $past(mem_rdata))
        else $error("data move write wrong");
    no_move_a: assert property (
        mem_wr |-> $past(tk_int) && $past(op) == SMLD_OP_MPCD_MOVE
        && $past(mem_raddr) > MAP_MMR_TOP)
        else $error("data move where none allowed");
    ptr_swap_a: assert property (
        tk_int && op_req.indirect && op_req.next_valid
        && op inside {SMLD_OP_MPCD_LOAD, SMLD_OP_MPCD_ACC,
        SMLD_OP_MPCD_MOVE, SMLD_OP_MPCD_PROD} |=>
        status_word_zero[15:13] == $past(op_req.next_ptr)
        && status_word_one[15:13] == $past(status_word_zero[15:13]))
        else $error("pointer buffer not updated");
endmodule

bind smld_unit smld_chk i_chk (.*);

//--- dv/tb.sv
// Self-checking testbench of the status and multiplicand load unit.
module tb
    import smld_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk, rst, op_valid, op_ready, op_done, mem_rd;
    logic        ext_wait, mem_wr, external_flag_pin;
    smld_req_t   op_req;
    logic [15:0] mem_raddr, mem_rdata, mem_waddr, mem_wdata, multiplicand;
    logic [15:0] status_word_zero, status_word_one;
    logic [31:0] product, accumulator;
    logic [79:0] exp_q[$];
    logic [79:0] exp_e;
    logic [15:0] mq = '0;
    logic [15:0] sw0 = ST0_RESET;
    logic [15:0] sw1 = ST1_RESET;
    logic [31:0] acc = '0;
    int          bad_count = 0;
    int          n_tests = 0;
    logic [15:0] adr[10] = '{16'h0002, 16'h0040, 16'h0061, 16'h007E,
        16'h007F, 16'h02FF, 16'h0300, 16'h03FE, 16'h03FF, 16'h8000};
    wire logic [79:0] seen = {multiplicand, accumulator, status_word_zero,
        status_word_one};

    smld_unit i_dut (.*);

    function automatic logic [15:0] dat(logic [15:0] a);
        return a * 16'h9E37 + 16'h1D0B;
    endfunction

    function automatic logic [31:0] shp(logic [31:0] p, logic [1:0] m);
        case (m)
            2'h1: return p << 1;
            2'h2: return p << 4;
            2'h3: return 32'($signed(p) >>> 6);
            default: return p;
        endcase
    endfunction

    assign mem_rdata = dat(mem_raddr);

    task automatic chk(logic [79:0] got, logic [79:0] want);
        n_tests++;
        if (got !== want) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Issues one operation at a falling edge and notes its outcome.
    task automatic issue(smld_op_t o, logic [15:0] a, logic nv, logic ind);
        logic [15:0] d;
        logic [15:0] ea;
        while (op_ready !== 1'b1) @(negedge ref_clk);
        // Direct operands take the page from the modelled status zero.
        ea = ind ? a : {sw0[8:0], a[6:0]};
        d = dat(ea);
        product = 32'($urandom_range(0, 65535));
        op_valid = 1'b1;
        op_req = '{o, ind, a[6:0], a, nv, 3'h5};
        case (o)
            SMLD_OP_RELOAD_ST0: sw0 = d & 16'hFDFF | sw0 & 16'h0200 | 16'h0400;
            SMLD_OP_RELOAD_ST1: begin
                sw1 = d | 16'h0180;
                sw0[15:13] = d[15:13];
            end
            SMLD_OP_MPCD_LOAD: mq = d;
            SMLD_OP_MPCD_PROD: begin
                mq = d;
                acc = shp(product, sw1[1:0]);
            end
            default: begin
                mq = d;
                acc = acc + shp(product, sw1[1:0]);
            end
        endcase
        if (ind && nv && o != SMLD_OP_RELOAD_ST0) begin
            sw1[15:13] = sw0[15:13];
            sw0[15:13] = 3'h5;
        end
        exp_q.push_back({mq, acc, sw0, sw1});
        @(negedge ref_clk);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk) ext_wait = 1'($urandom_range(0, 1));

    always @(posedge ref_clk) begin
        #1;
        if (op_done === 1'b1) begin
            chk(80'(exp_q.size() > 0), 80'h1);
            exp_e = exp_q.pop_front();
            chk(seen, exp_e);
            chk(80'(external_flag_pin), 80'(exp_e[4]));
        end
    end

    initial begin
        smld_op_t    o;
        logic [15:0] a;
        void'($urandom(29));
        rst = 1'b1;
        op_valid = 1'b0;
        op_req = '0;
        ext_wait = 1'b0;
        product = '0;
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        chk(seen, {mq, acc, sw0, sw1});
        // Back-to-back operations stand in for repeated execution.
        for (int i = 0; i < 400; i++) begin
            o = smld_op_t'($urandom_range(0, 5));
            a = i[0] ? adr[$urandom_range(0, 9)] : 16'($urandom_range(0, 1023));
            issue(o, a, i[1], i[2] | i[0]);
        end
        op_valid = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk(80'(exp_q.size()), 80'h0);
        give_verdict();
    end

    initial begin
        #100us;
        bad_count++;
        give_verdict();
    end
endmodule
